/* sacif_top.sv */
// sacif_top: serial conversion sequencer and four-wire interface
// assumes: chip select, serial clock and control input are pins
// sampled by clock_i; converter core returns result on sample request
// Notes on behaviour
// - each conversion and its result transfer take exactly 16 serial clocks
// - chip select fall starts conversions; they repeat while it stays low
// - control loads during a conversion, applies to the next one
// - result output is driven from chip select fall onward
// - track on first internal fall, hold and sample on fourth fall
// - internal serial clock is gated off while chip select is high
// - clock low at chip select rise: next select fall is first fall
// - clock high at chip select rise: first real fall starts tracking
// - four zeros then twelve result bits, msb first, changed on falls
// - result lsb driven on 16th fall, held through next rise
// - control captured msb first on first 8 rises, rest ignored
// - control register resets to all zeros
// - control bits 5..3 pick channel, channel 7 selects ground
// - powered down while deselected and after 16th fall until next
`default_nettype none
module sacif_top #(
	parameter int RESULT_W = sacif_pkg::RESULT_BITS,
	parameter int DEPTH    = sacif_pkg::FIFO_DEPTH
) (
	// clock and reset
	input  wire logic                clock_i,
	input  wire logic                rst_n_i,
	input  wire logic                ce_i,
	// serial pins
	input  wire logic                chip_sel_n_i,
	input  wire logic                sclk_i,
	input  wire logic                ctrl_in_i,
	output logic                     result_out_o,
	output logic                     result_oe_o,
	// converter core
	input  wire logic                core_valid_i,
	output logic                     core_ready_o,
	input  wire logic [RESULT_W-1:0] core_data_i,
	output logic                     sample_o,
	output logic [2:0]               channel_o,
	output logic                     ground_sel_o,
	// status
	output logic                     tracking_o,
	output logic                     powered_o,
	output logic [7:0]               ctrl_reg_o
);
	initial
	begin
		if (RESULT_W != sacif_pkg::RESULT_BITS)
			$error("sacif_top: result width must be twelve");
	end

	typedef enum logic [1:0] {
		SACIF_IDLE = 2'b00,
		SACIF_RUN  = 2'b01,
		SACIF_GAP  = 2'b10
	} sacif_state_e;

	function automatic logic ch_is_ground(input logic [2:0] c);
		ch_is_ground = (c == sacif_pkg::CH_GROUND);
	endfunction

	// synchronised pins
	logic cs_n;
	logic sclk;
	logic din;
	sacif_sync3 #(.INIT(1'b1)) u_cs (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.async_i (chip_sel_n_i),
		.level_o (cs_n)
	);
	sacif_sync3 #(.INIT(1'b0)) u_sclk (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.async_i (sclk_i),
		.level_o (sclk)
	);
	sacif_sync3 #(.INIT(1'b0)) u_din (
		.clock_i (clock_i),
		.rst_n_i (rst_n_i),
		.ce_i    (ce_i),
		.async_i (ctrl_in_i),
		.level_o (din)
	);

	// state
	sacif_state_e                      state_reg;
	sacif_state_e                      state_next;
	logic                              cs_n_d_reg;
	logic                              sclk_d_reg;
	logic                              low_at_rise_reg;
	logic [sacif_pkg::CNT_W-1:0]       fall_reg;
	logic [sacif_pkg::CNT_W-1:0]       rise_reg;
	logic [7:0]                        shift_reg;
	logic [7:0]                        ctrl_reg;
	logic [15:0]                       out_reg;
	logic                              dout_reg;
	logic                              oe_reg;
	logic                              sample_reg;
	logic                              track_reg;

	// result words from the core pass through the fifo
	logic                              res_valid;
	logic [RESULT_W-1:0]               res_data;
	logic                              res_take;

	sacif_fifo #(.WIDTH(RESULT_W), .DEPTH(DEPTH)) u_fifo (
		.clock_i     (clock_i),
		.rst_n_i     (rst_n_i),
		.ce_i        (ce_i),
		.in_valid_i  (core_valid_i),
		.in_ready_o  (core_ready_o),
		.in_data_i   (core_data_i),
		.out_valid_o (res_valid),
		.out_ready_i (res_take),
		.out_data_o  (res_data)
	);

	// edge decode
	wire cs_fall   = cs_n_d_reg && !cs_n;
	wire cs_rise   = !cs_n_d_reg && cs_n;
	wire sel       = !cs_n;
	wire raw_fall  = sclk_d_reg && !sclk;
	wire raw_rise  = !sclk_d_reg && sclk;
	// internal clock gated by chip select
	wire int_fall  = sel && !cs_fall && raw_fall;
	wire int_rise  = sel && !cs_fall && raw_rise;
	// select fall with clock low at last rise acts as a fall
	wire synth_fall = cs_fall && low_at_rise_reg;
	wire fall      = int_fall || synth_fall;
	wire last_fall = fall && (fall_reg ==
		sacif_pkg::CNT_W'(sacif_pkg::CONV_EDGES - 1));
	wire hold_fall = fall && (fall_reg ==
		sacif_pkg::CNT_W'(sacif_pkg::HOLD_EDGE - 1));
	wire ctrl_rise = int_rise && (rise_reg <
		sacif_pkg::CNT_W'(sacif_pkg::CTRL_BITS));
	wire ctrl_done = int_rise && (rise_reg ==
		sacif_pkg::CNT_W'(sacif_pkg::CTRL_BITS - 1));
	wire first_fall = fall && (fall_reg == '0);
	// result word taken at the point of sampling, for this conversion
	assign res_take = hold_fall;

	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			SACIF_IDLE:
				if (cs_fall)
					state_next = SACIF_RUN;
			SACIF_RUN:
				if (cs_n)
					state_next = SACIF_IDLE;
				else if (last_fall)
					state_next = SACIF_GAP;
			SACIF_GAP:
				if (cs_n)
					state_next = SACIF_IDLE;
				else if (fall)
					state_next = SACIF_RUN;
			default:
				state_next = SACIF_IDLE;
		endcase
	end

	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			state_reg       <= SACIF_IDLE;
			cs_n_d_reg      <= 1'b1;
			sclk_d_reg      <= 1'b0;
			low_at_rise_reg <= 1'b0;
		end
		else if (ce_i)
		begin
			state_reg  <= state_next;
			cs_n_d_reg <= cs_n;
			sclk_d_reg <= sclk;
			if (cs_rise)
				low_at_rise_reg <= !sclk;
		end
	end

	// edge counters
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			fall_reg <= '0;
			rise_reg <= '0;
		end
		else if (ce_i)
		begin
			if (cs_n || cs_fall)
			begin
				fall_reg <= '0;
				rise_reg <= '0;
			end
			else if (last_fall)
			begin
				fall_reg <= '0;
				rise_reg <= '0;
			end
			else
			begin
				if (fall)
					fall_reg <= fall_reg + 1'b1;
				if (int_rise && fall_reg != '0)
					rise_reg <= rise_reg + 1'b1;
			end
			// a fall synthesised at select fall counts too
			if (synth_fall)
				fall_reg <= sacif_pkg::CNT_W'(1);
		end
	end

	// control register: new value affects the next conversion only
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			shift_reg <= sacif_pkg::CTRL_RESET;
			ctrl_reg  <= sacif_pkg::CTRL_RESET;
		end
		else if (ce_i)
		begin
			if (ctrl_rise && fall_reg != '0)
				shift_reg <= {shift_reg[6:0], din};
			if (ctrl_done && fall_reg != '0)
				ctrl_reg <= {shift_reg[6:0], din};
		end
	end

	// channel latched at track start, from last complete control load
	logic [2:0] chan_reg;
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
			chan_reg <= 3'h0;
		else if (ce_i && first_fall)
			chan_reg <= ctrl_reg[sacif_pkg::CH_HI:sacif_pkg::CH_LO];
	end

	// result shifter: zeros then result, one bit per fall
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			out_reg  <= '0;
			dout_reg <= 1'b0;
			oe_reg   <= 1'b0;
		end
		else if (ce_i)
		begin
			oe_reg <= sel;
			if (cs_fall)
				dout_reg <= 1'b0;
			if (first_fall)
			begin
				out_reg  <= {{sacif_pkg::LEAD_ZEROS{1'b0}},
					res_valid ? res_data : {RESULT_W{1'b0}}} << 1;
				dout_reg <= 1'b0;
			end
			else if (fall && state_reg == SACIF_RUN)
			begin
				dout_reg <= out_reg[15];
				out_reg  <= {out_reg[14:0], 1'b0};
			end
		end
	end

	// track and sample strobes
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			sample_reg <= 1'b0;
			track_reg  <= 1'b0;
		end
		else if (ce_i)
		begin
			sample_reg <= hold_fall && sel;
			if (cs_n)
				track_reg <= 1'b0;
			else if (first_fall)
				track_reg <= 1'b1;
			else if (hold_fall)
				track_reg <= 1'b0;
		end
	end

	assign result_out_o = dout_reg;
	assign result_oe_o  = oe_reg;
	assign sample_o     = sample_reg;
	assign channel_o    = chan_reg;
	assign ground_sel_o = ch_is_ground(chan_reg);
	assign tracking_o   = track_reg;
	// powered only inside a conversion
	assign powered_o    = state_reg == SACIF_RUN;
	assign ctrl_reg_o   = ctrl_reg;
endmodule
`default_nettype wire

/* sacif_pkg.sv */
// sacif_pkg: constants for the serial conversion interface
// assumes: used by sacif_top only
`default_nettype none
package sacif_pkg;
	localparam int CONV_EDGES    = 16;
	localparam int LEAD_ZEROS    = 4;
	localparam int RESULT_BITS   = 12;
	localparam int CTRL_BITS     = 8;
	localparam int HOLD_EDGE     = 4;
	localparam int CNT_W         = 5;
	localparam int CH_HI         = 5;
	localparam int CH_LO         = 3;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [2:0] CH_GROUND  = 3'h7;
	localparam int FIFO_DEPTH    = 16;
endpackage
`default_nettype wire

/* sacif_sync3.sv */
// sacif_sync3: three-flop synchroniser with agreement filter
// assumes: async input, clock enable freezes state
`default_nettype none
module sacif_sync3 #(
	parameter logic INIT = 1'b0
) (
	// clock
	input  wire logic clock_i,
	input  wire logic rst_n_i,
	input  wire logic ce_i,
	// signal
	input  wire logic async_i,
	output logic      level_o
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	logic lvl_reg;
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			s1_reg  <= INIT;
			s2_reg  <= INIT;
			s3_reg  <= INIT;
			lvl_reg <= INIT;
		end
		else if (ce_i)
		begin
			s1_reg <= async_i;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			// change counts once the last two agree
			if (s2_reg == s3_reg)
				lvl_reg <= s3_reg;
		end
	end
	assign level_o = lvl_reg;
endmodule
`default_nettype wire

/* sacif_fifo.sv */
// sacif_fifo: valid/ready word fifo, registered read data
// assumes: single clock, clock enable freezes state
`default_nettype none
module sacif_fifo #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 16
) (
	// clock
	input  wire logic             clock_i,
	input  wire logic             rst_n_i,
	input  wire logic             ce_i,
	// write side
	input  wire logic             in_valid_i,
	output logic                  in_ready_o,
	input  wire logic [WIDTH-1:0] in_data_i,
	// read side
	output logic                  out_valid_o,
	input  wire logic             out_ready_i,
	output logic [WIDTH-1:0]      out_data_o
);
	localparam int AW = $clog2(DEPTH);
	initial
	begin
		if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1)
			$error("sacif_fifo: depth must be power of two >= 2");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wp_reg;
	logic [AW:0]      rp_reg;
	logic             ov_reg;
	logic [WIDTH-1:0] od_reg;
	wire  [AW:0]      count = wp_reg - rp_reg;
	// the output register holds a word too, so it counts toward depth
	wire              full  = (count == (AW+1)'(DEPTH)) ||
		(ov_reg && count == (AW+1)'(DEPTH - 1));
	wire              empty = count == '0;
	wire              wr    = in_valid_i && !full;
	// output register refills when empty or being taken
	wire              load  = !empty && (!ov_reg || out_ready_i);
	wire              drop  = ov_reg && out_ready_i && !load;
	assign in_ready_o  = !full;
	assign out_valid_o = ov_reg;
	assign out_data_o  = od_reg;
	always_ff @(posedge clock_i)
	begin
		if (ce_i && wr)
			mem[wp_reg[AW-1:0]] <= in_data_i;
	end
	always_ff @(posedge clock_i)
	begin
		if (!rst_n_i)
		begin
			wp_reg <= '0;
			rp_reg <= '0;
			ov_reg <= 1'b0;
			od_reg <= '0;
		end
		else if (ce_i)
		begin
			if (wr)
				wp_reg <= wp_reg + 1'b1;
			if (load)
			begin
				od_reg <= mem[rp_reg[AW-1:0]];
				rp_reg <= rp_reg + 1'b1;
				ov_reg <= 1'b1;
			end
			else if (drop)
				ov_reg <= 1'b0;
		end
	end
endmodule
`default_nettype wire

/* sacif_asserts.sv */
// sacif_asserts: port-level checks of the conversion sequencer
// assumes: bound to sacif_top, sclk holds each level >= 4 clocks
`default_nettype none
module sacif_asserts (
	// clock and reset
	input wire logic       clock_i,
	input wire logic       rst_n_i,
	// pins
	input wire logic       chip_sel_n_i,
	input wire logic       sclk_i,
	input wire logic       result_out_o,
	input wire logic       result_oe_o,
	// status
	input wire logic       sample_o,
	input wire logic [2:0] channel_o,
	input wire logic       ground_sel_o,
	input wire logic       tracking_o,
	input wire logic       powered_o,
	input wire logic [7:0] ctrl_reg_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!rst_n_i);
	AST_OE_ON: assert property (!chip_sel_n_i [*8] |-> result_oe_o)
		else $error("result pin idle in frame");
	AST_OE_OFF: assert property (chip_sel_n_i [*8] |-> !result_oe_o)
		else $error("result pin driven while deselected");
	AST_GATED: assert property (chip_sel_n_i [*8] |->
		!powered_o && !tracking_o && !sample_o)
		else $error("activity while deselected");
	AST_PULSE: assert property (sample_o |=> !sample_o)
		else $error("sample pulse too long");
	AST_HOLD: assert property (sample_o |-> ##[0:1] !tracking_o)
		else $error("tracking past hold");
	// power comes up at select fall, tracking only at the first fall
	AST_START: assert property (tracking_o |-> powered_o)
		else $error("tracking while powered down");
	AST_GROUND: assert property (ground_sel_o == (channel_o == 3'h7))
		else $error("ground select mismatch");
	AST_CTRL_IDLE: assert property (chip_sel_n_i [*8] |=>
		$stable(ctrl_reg_o))
		else $error("control changed while deselected");
	AST_CTRL_LOAD: assert property ($changed(ctrl_reg_o) |->
		powered_o && !tracking_o)
		else $error("control loaded outside conversion");
	// a bit may only move on a fall seen through the 5-cycle sync path
	AST_DOUT_FALL: assert property ($changed(result_out_o) &&
		result_oe_o && $past(result_oe_o) |-> !$past(sclk_i, 5))
		else $error("result bit moved without a fall");
endmodule
`default_nettype wire

/* sacif_host.sv */
// sacif_host: host model driving frames on the serial pins
// assumes: 40 MHz clock_i, sclk period 8 clocks (200 ns)
`default_nettype none
module sacif_host (
	// clock
	input wire logic clock_i,
	// pins
	output logic     cs_n_o,
	output logic     sclk_o,
	output logic     din_o,
	input wire logic dout_i
);
	timeunit 1ns;
	timeprecision 1ps;
	logic skip;
	initial
	begin
		cs_n_o = 1'b1;
		sclk_o = 1'b1;
		din_o = 1'b0;
		skip = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge clock_i);
	endtask
	task automatic open_frame();
		skip = !sclk_o;
		cs_n_o <= 1'b0;
		tick(4);
	endtask
	// bit read 3 clocks after the rise: the pin path lags 5 clocks
	task automatic conv(input logic [7:0] c, output logic [15:0] got);
		logic lead;
		lead = skip;
		for (int i = 0; i < 16; i++)
		begin
			if (!skip)
				sclk_o <= 1'b0;
			skip = 1'b0;
			din_o <= (i < 8) ? c[7 - i] : i[0];
			tick(4);
			sclk_o <= 1'b1;
			tick(3);
			got[15 - i] = (lead && i == 0) ? 1'b0 : dout_i;
			tick(1);
		end
	endtask
	task automatic close_frame(input logic low);
		if (low)
		begin
			sclk_o <= 1'b0;
			tick(4);
		end
		cs_n_o <= 1'b1;
		tick(8);
	endtask
	task automatic wiggle(input int n);
		repeat (n)
		begin
			sclk_o <= !sclk_o;
			tick(4);
		end
	endtask
endmodule
`default_nettype wire

/* sacif_top_tb.sv */
// sacif_top_tb: self-checking bench for the conversion interface
// assumes: host model owns the pins, bench feeds the core side
`default_nettype none
`define CHECK(a, b) \
	begin \
		total_checks++; \
		if ((a) !== (b)) \
		begin \
			num_errors++; \
			$display("unexpected at %0t: %h vs %h", $time, a, b); \
		end \
	end
module sacif_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        clock_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        core_valid_i = 1'b0;
	logic [11:0] core_data_i = 12'h000;
	logic        cs_n, sclk, din, dout, oe, rdy, smp, gnd, trk, pwr;
	logic [2:0]  chan;
	logic [7:0]  ctrl;
	logic [7:0]  prev = 8'h00;
	logic [11:0] words[$];
	int          num_errors = 0;
	int          total_checks = 0;
	int          cycles = 0;
	int          samples = 0;
	always #12.5 clock_i = !clock_i;
	always @(posedge clock_i)
	begin
		cycles++;
		samples += int'(smp === 1'b1);
		if (cycles == 12000)
		begin
			num_errors++;
			conclude();
		end
	end
	sacif_top uut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.chip_sel_n_i(cs_n), .sclk_i(sclk), .ctrl_in_i(din),
		.result_out_o(dout), .result_oe_o(oe), .core_valid_i(core_valid_i),
		.core_ready_o(rdy), .core_data_i(core_data_i), .sample_o(smp),
		.channel_o(chan), .ground_sel_o(gnd), .tracking_o(trk),
		.powered_o(pwr), .ctrl_reg_o(ctrl));
	sacif_host host (.clock_i(clock_i), .cs_n_o(cs_n), .sclk_o(sclk),
		.din_o(din), .dout_i(dout));
	task automatic conclude();
		if (num_errors == 0 && total_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic convs(input int n, input logic [7:0] base);
		logic [15:0] got;
		logic [7:0]  c;
		logic [11:0] w;
		for (int k = 0; k < n; k++)
		begin
			c = base | 8'(k << 3);
			w = (words.size() > 0) ? words.pop_front() : 12'h000;
			host.conv(c, got);
			`CHECK(got, {4'h0, w})
			`CHECK(ctrl, c)
			`CHECK(chan, prev[5:3])
			`CHECK(gnd, prev[5:3] == 3'h7)
			`CHECK(pwr, 1'b0)
			prev = c;
		end
	endtask
	task automatic t_reset();
		`CHECK(ctrl, 8'h00)
		`CHECK(chan, 3'h0)
		`CHECK(oe, 1'b0)
		`CHECK(pwr, 1'b0)
	endtask
	// extra words while full must be refused, not overwrite the head
	task automatic t_fill();
		for (int i = 0; i < 16; i++)
		begin
			core_valid_i <= 1'b1;
			core_data_i <= {i[3:0], ~i[3:0], 4'h5};
			words.push_back({i[3:0], ~i[3:0], 4'h5});
			@(posedge clock_i);
		end
		core_data_i <= 12'hFFF;
		repeat (2) @(posedge clock_i);
		core_valid_i <= 1'b0;
		`CHECK(rdy, 1'b0)
	endtask
	task automatic t_channels();
		host.open_frame();
		convs(8, 8'hC7);
		host.close_frame(1'b1);
	endtask
	task automatic t_low_start();
		host.open_frame();
		convs(8, 8'h00);
		host.close_frame(1'b0);
		`CHECK(oe, 1'b0)
		`CHECK(rdy, 1'b1)
	endtask
	task automatic t_gated();
		host.wiggle(6);
		`CHECK(ctrl, prev)
		`CHECK(pwr, 1'b0)
		`CHECK(samples, 16)
	endtask
	task automatic t_empty();
		host.open_frame();
		convs(1, 8'h28);
		host.close_frame(1'b0);
	endtask
	initial
	begin
		repeat (16) @(posedge clock_i);
		rst_n_i <= 1'b1;
		repeat (4) @(posedge clock_i);
		t_reset();
		t_fill();
		t_channels();
		t_low_start();
		t_gated();
		t_empty();
		conclude();
	end
endmodule
bind sacif_top sacif_asserts chk (.clock_i(clock_i), .rst_n_i(rst_n_i),
	.chip_sel_n_i(chip_sel_n_i), .sclk_i(sclk_i),
	.result_out_o(result_out_o), .result_oe_o(result_oe_o),
	.sample_o(sample_o), .channel_o(channel_o),
	.ground_sel_o(ground_sel_o), .tracking_o(tracking_o),
	.powered_o(powered_o), .ctrl_reg_o(ctrl_reg_o));
`default_nettype wire
